// >>> amp_diag_defines.svh
// Offsets, field positions, reset values and codes of the diagnostic
// status register group. Definitions only; included by bare name.
`ifndef AMP_DIAG_DEFINES_SVH
`define AMP_DIAG_DEFINES_SVH

// Register offsets on the internal register port
`define OFS_SHORT_THR_CH34    8'h0B
`define OFS_DIAG_RES_CH12     8'h0C
`define OFS_DIAG_RES_CH34     8'h0D
`define OFS_LINE_OUT_DET      8'h0E
`define OFS_STATE_READBACK    8'h0F
`define OFS_CHAN_FAULTS       8'h10
`define OFS_GLOBAL_FAULTS     8'h11

// Reset values
`define RST_SHORT_THR_CH34    8'h11
`define RST_DIAG_RES          8'h00
`define RST_LINE_OUT_DET      8'h00
`define RST_STATE_READBACK    8'h55
`define RST_CHAN_FAULTS       8'h00
`define RST_GLOBAL_FAULTS     8'h00

// Threshold code fields in the threshold register
`define THR_CH3_MSB           7
`define THR_CH3_LSB           4
`define THR_CH4_MSB           3
`define THR_CH4_LSB           0

// Highest defined threshold code; above it the code is reserved
`define THR_CODE_MAX          4'h9
`define THR_CODE_WIDTH        4

// Field positions in the global fault register
`define GF_INVALID_CLOCK      4
`define GF_PSTAGE_OV          3
`define GF_BATT_OV            2
`define GF_PSTAGE_UV          1
`define GF_BATT_UV            0

`endif

// >>> amp_diag_pkg.sv
// Types shared by the diagnostic status register group.
// Assumes the defines header is compiled alongside.
package amp_diag_pkg;

	// Reported per-channel operating state
	typedef enum logic [1:0] {
		STATE_PLAY = 2'b00,
		STATE_HIZ  = 2'b01,
		STATE_MUTE = 2'b10,
		STATE_DIAG = 2'b11
	} chan_state_t;

	// Per-channel DC diagnostic flags, MSB first as in the register
	typedef struct packed {
		logic shortToGround;
		logic shortToSupply;
		logic openLoad;
		logic shortedLoad;
	} diag_flags_t;

	// Raw outcome of one DC diagnostic run on one channel
	typedef struct packed {
		logic       done;
		logic       shortToGround;
		logic       shortToSupply;
		logic       openLoad;
		logic [7:0] loadHalfOhm;
	} diag_meas_t;

	// Global supply and clock fault events
	typedef struct packed {
		logic invalidClock;
		logic pstageOv;
		logic battOv;
		logic pstageUv;
		logic battUv;
	} global_fault_t;

endpackage

// >>> diag_channel_result.sv
// Holds the DC diagnostic flags of one channel.
// Assumes a measurement arrives with a one-cycle done pulse.
`timescale 1ns/1ns
module diag_channel_result (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// Threshold in half-ohm units and its validity
	input  wire logic [4:0]                thrHalfOhm,
	input  wire logic                      thrValid,
	// Measurement from the analog detector
	input  wire amp_diag_pkg::diag_meas_t  meas,
	// Latched flags
	output amp_diag_pkg::diag_flags_t      flags
);

	amp_diag_pkg::diag_flags_t flags_reg;
	amp_diag_pkg::diag_flags_t flags_next;
	wire logic                 belowThr;

	// A reserved code never marks a load as shorted
	assign belowThr = thrValid && (meas.loadHalfOhm < {3'b000, thrHalfOhm});

	// Each run replaces all four flags, so stale results cannot linger
	assign flags_next = meas.done ?
		amp_diag_pkg::diag_flags_t'({meas.shortToGround, meas.shortToSupply,
			meas.openLoad, belowThr}) : flags_reg;

	always_ff @(posedge clk) begin
		if (rst)
			flags_reg <= '0;
		else
			flags_reg <= flags_next;
	end

	assign flags = flags_reg;

endmodule

// >>> channel_state_report.sv
// Derives the reported operating state of one channel.
// Assumes the power stage reports the state it has actually reached.
`timescale 1ns/1ns
module channel_state_report (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// State applied by the output stage and diagnostic activity
	input  wire amp_diag_pkg::chan_state_t  appliedState,
	input  wire logic                       diagRunning,
	// Reported state
	output amp_diag_pkg::chan_state_t       state
);

	amp_diag_pkg::chan_state_t state_reg;
	amp_diag_pkg::chan_state_t state_next;

	// A running diagnostic overrides whatever the stage reports
	assign state_next = diagRunning ? amp_diag_pkg::STATE_DIAG
		: appliedState;

	always_ff @(posedge clk) begin
		if (rst)
			state_reg <= amp_diag_pkg::STATE_HIZ;
		else
			state_reg <= state_next;
	end

	assign state = state_reg;

endmodule

// >>> amp_diag_fault_status_regs.sv
// Operation
// [RULE_01] Threshold register 0x0B, ch3 high, ch4 low, 0x11
// [RULE_02] Code selects shorted-load ohms, 0000 is half-ohm
// [RULE_03] Half-ohm steps; codes above 1001 reserved
// [RULE_04] Result register 0x0C holds ch1 and ch2 flags
// [RULE_05] Result register 0x0D holds ch3 and ch4 flags
// [RULE_06] Short-to-ground flag set when found
// [RULE_07] Short-to-supply flag set when found
// [RULE_08] Open-load flag set when found
// [RULE_09] Shorted-load flag when load below threshold
// [RULE_10] Line-output flags at 0x0E, upper nibble zero
// [RULE_11] State readback at 0x0F, resets 0x55
// [RULE_12] States: play, high-Z, mute, diagnostics
// [RULE_13] Host requests states through register 0x04
// [RULE_14] Channel fault register 0x10: overcurrent, DC
// [RULE_15] Overcurrent flag set once fault detected
// [RULE_16] DC-fault flag set once offset detected
// [RULE_17] Global fault register 0x11, supply and clock
// [RULE_18] Diagnostic fault reaches pin only when enabled
// [RULE_19] Writes to status registers are ignored
//
// Diagnostic and protection status register group of a four-channel
// amplifier. Assumes the serial control front end turns bus transfers
// into single-cycle read and write strobes on the register port, and
// that the analog detectors deliver synchronous events.
`timescale 1ns/1ns
`include "amp_diag_defines.svh"
module amp_diag_fault_status_regs (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst,
	// Register port from the serial control front end
	input  wire logic [7:0]                   regAddr,
	input  wire logic                         regWrite,
	input  wire logic [7:0]                   regWrData,
	input  wire logic                         regRead,
	output logic [7:0]                        regRdData,
	output logic                              regRdValid,
	// Thresholds of ch1 and ch2, held in a neighbouring register
	input  wire logic [7:0]                   shortThresholdCh12,
	// DC diagnostic measurements, index 0 is channel 1
	input  wire amp_diag_pkg::diag_meas_t     diagMeas [4],
	input  wire logic [3:0]                   diagRunning,
	input  wire logic [3:0]                   lineOutputDetect,
	input  wire logic                         lineOutputDone,
	// Channel state reached by each output stage
	input  wire amp_diag_pkg::chan_state_t    appliedState [4],
	// Protection events
	input  wire logic [3:0]                   overcurrentEvent,
	input  wire logic [3:0]                   dcOffsetEvent,
	input  wire amp_diag_pkg::global_fault_t  globalFaultEvent,
	// Report control and fault pin contribution
	input  wire logic                         diagReportEnable,
	output logic                              diagFaultToPin,
	// Threshold codes for the detector of ch3 and ch4
	output logic [3:0]                        shortThresholdCodeCh3,
	output logic [3:0]                        shortThresholdCodeCh4
);

	// Threshold code decoding, used for every channel
	function automatic logic thrCodeValid(input logic [3:0] code);
		thrCodeValid = (code <= `THR_CODE_MAX);
	endfunction

	// Code n stands for (n+1) half-ohms, from 0.5 up to 5 ohms
	function automatic logic [4:0] thrCodeHalfOhm(input logic [3:0] code);
		thrCodeHalfOhm = {1'b0, code} + 5'h01;
	endfunction

	// Register state
	logic [7:0]                 shortThr_reg;
	logic [7:0]                 shortThr_next;
	logic [3:0]                 lineOut_reg;
	logic [3:0]                 lineOut_next;
	logic [3:0]                 overcurrent_reg;
	logic [3:0]                 overcurrent_next;
	logic [3:0]                 dcFault_reg;
	logic [3:0]                 dcFault_next;
	logic [4:0]                 globalFault_reg;
	logic [4:0]                 globalFault_next;
	logic [7:0]                 rdData_reg;
	logic [7:0]                 rdData_next;
	logic                       rdValid_reg;

	// Decoded accesses
	wire logic                  wrThr;
	wire logic                  rdChanFaults;
	wire logic                  rdGlobalFaults;

	// Per-channel views
	wire logic [3:0]            thrCode   [4];
	amp_diag_pkg::diag_flags_t  diagFlags [4];
	amp_diag_pkg::chan_state_t  repState  [4];
	wire logic [7:0]            diagResCh12;
	wire logic [7:0]            diagResCh34;
	wire logic [7:0]            stateReadback;
	wire logic [7:0]            chanFaults;
	wire logic [7:0]            globalFaults;
	wire logic                  anyDiagFault;

	// Only the threshold register accepts writes
	assign wrThr = regWrite && (regAddr == `OFS_SHORT_THR_CH34); // [RULE_01]

	// Writes to every other offset fall through untouched
	// [RULE_19]
	assign shortThr_next = wrThr ? regWrData : shortThr_reg;

	// Reads of the fault registers also clear what they returned
	assign rdChanFaults   = regRead && (regAddr == `OFS_CHAN_FAULTS);
	assign rdGlobalFaults = regRead && (regAddr == `OFS_GLOBAL_FAULTS);

	// Threshold codes of all four channels
	assign thrCode[0] = shortThresholdCh12[7:4];
	assign thrCode[1] = shortThresholdCh12[3:0];
	assign thrCode[2] = shortThr_reg[`THR_CH3_MSB:`THR_CH3_LSB]; // [RULE_01]
	assign thrCode[3] = shortThr_reg[`THR_CH4_MSB:`THR_CH4_LSB]; // [RULE_01]

	assign shortThresholdCodeCh3 = thrCode[2];
	assign shortThresholdCodeCh4 = thrCode[3];

	// One result holder and one state tracker per channel
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch = ch + 1) begin : gChan
			// Threshold decode: half-ohm steps, reserved codes off
			diag_channel_result uResult (
				.clk       (clk),
				.rst       (rst),
				.thrHalfOhm(thrCodeHalfOhm(thrCode[ch])), // [RULE_02] [RULE_03]
				.thrValid  (thrCodeValid(thrCode[ch])),   // [RULE_03] [RULE_09]
				.meas      (diagMeas[ch]),                // [RULE_06] [RULE_07] [RULE_08]
				.flags     (diagFlags[ch])
			);

			// Reported state follows what the stage applied
			channel_state_report uState (
				.clk         (clk),
				.rst         (rst),
				.appliedState(appliedState[ch]), // [RULE_13]
				.diagRunning (diagRunning[ch]),  // [RULE_12]
				.state       (repState[ch])
			);
		end
	endgenerate

	// Result registers, channel with lower number in the upper nibble
	assign diagResCh12 = {diagFlags[0], diagFlags[1]}; // [RULE_04]
	assign diagResCh34 = {diagFlags[2], diagFlags[3]}; // [RULE_05]

	// State readback, channel 1 in the top two bits
	assign stateReadback = {repState[0], repState[1],
		repState[2], repState[3]}; // [RULE_11] [RULE_12]

	// Line output flags are refreshed only when a line check completes
	assign lineOut_next = lineOutputDone ? lineOutputDetect : lineOut_reg;

	// Sticky protection flags; a new event beats a clearing read
	// [RULE_15]
	assign overcurrent_next = overcurrentEvent |
		(rdChanFaults ? 4'h0 : overcurrent_reg);
	// [RULE_16]
	assign dcFault_next = dcOffsetEvent |
		(rdChanFaults ? 4'h0 : dcFault_reg);
	// [RULE_17]
	assign globalFault_next = globalFaultEvent |
		(rdGlobalFaults ? 5'h00 : globalFault_reg);

	// Channel fault register: overcurrent high nibble, DC low nibble
	assign chanFaults = {overcurrent_reg, dcFault_reg}; // [RULE_14]

	// Global fault register with the three reserved bits at zero
	assign globalFaults = {3'b000, globalFault_reg}; // [RULE_17]

	// A diagnostic fault reaches the pin only when reporting is enabled
	assign anyDiagFault = |diagResCh12 || |diagResCh34;
	assign diagFaultToPin = diagReportEnable && anyDiagFault; // [RULE_18]

	// Read multiplexer; unmapped offsets in this group read zero
	always_comb begin
		rdData_next = rdData_reg;
		if (regRead) begin
			case (regAddr)
				`OFS_SHORT_THR_CH34: rdData_next = shortThr_reg;
				`OFS_DIAG_RES_CH12:  rdData_next = diagResCh12;
				`OFS_DIAG_RES_CH34:  rdData_next = diagResCh34;
				`OFS_LINE_OUT_DET:   rdData_next = {4'h0, lineOut_reg}; // [RULE_10]
				`OFS_STATE_READBACK: rdData_next = stateReadback;
				`OFS_CHAN_FAULTS:    rdData_next = chanFaults;
				`OFS_GLOBAL_FAULTS:  rdData_next = globalFaults;
				default:             rdData_next = 8'h00;
			endcase
		end
	end

	// Threshold and line output state
	always_ff @(posedge clk) begin
		if (rst) begin
			shortThr_reg <= `RST_SHORT_THR_CH34; // [RULE_01]
			lineOut_reg  <= 4'h0;
		end else begin
			shortThr_reg <= shortThr_next;
			lineOut_reg  <= lineOut_next;
		end
	end

	// Protection flags
	always_ff @(posedge clk) begin
		if (rst) begin
			overcurrent_reg <= 4'h0;
			dcFault_reg     <= 4'h0;
			globalFault_reg <= 5'h00;
		end else begin
			overcurrent_reg <= overcurrent_next;
			dcFault_reg     <= dcFault_next;
			globalFault_reg <= globalFault_next;
		end
	end

	// Read data is held until the next read so the front end can shift it
	always_ff @(posedge clk) begin
		if (rst) begin
			rdData_reg  <= 8'h00;
			rdValid_reg <= 1'b0;
		end else begin
			rdData_reg  <= rdData_next;
			rdValid_reg <= regRead;
		end
	end

	assign regRdData  = rdData_reg;
	assign regRdValid = rdValid_reg;

endmodule

// >>> amp_diag_fault_status_regs_asserts.sv
// Assertions on the ports of the diagnostic status register group.
// Assumes strobe timing of the register port as handed over.
`timescale 1ns/1ns
module amp_diag_fault_status_regs_asserts (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic       regWrite,
	input wire logic [7:0] regWrData,
	input wire logic       regRead,
	input wire logic [7:0] regRdData,
	input wire logic       regRdValid,
	// Events and fault pin
	input wire logic [3:0] diagRunning,
	input wire logic [3:0] overcurrentEvent,
	input wire logic [3:0] dcOffsetEvent,
	input wire logic       diagReportEnable,
	input wire logic       diagFaultToPin,
	// Threshold codes
	input wire logic [3:0] shortThresholdCodeCh3,
	input wire logic [3:0] shortThresholdCodeCh4
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Threshold write decode, shared by two checks
	wire thrWr = regWrite && regAddr == 8'h0B;
	a_thr_write_lands:
		assert property (thrWr |=> {shortThresholdCodeCh3,
			shortThresholdCodeCh4} == $past(regWrData)) else $error("code lost");
	a_thr_holds:
		assert property (!thrWr |=> $stable(shortThresholdCodeCh3)
			&& $stable(shortThresholdCodeCh4)) else $error("code moved");
	a_line_rsvd_zero:
		assert property (regRdValid && $past(regAddr) == 8'h0E
			|-> regRdData[7:4] == 4'h0) else $error("line reserved set");
	a_glob_rsvd_zero:
		assert property (regRdValid && $past(regAddr) == 8'h11
			|-> regRdData[7:5] == 3'h0) else $error("global reserved set");
	a_pin_masked:
		assert property (!diagReportEnable |-> !diagFaultToPin)
			else $error("pin not masked");
	a_diag_state_shown:
		assert property (regRead && regAddr == 8'h0F && diagRunning[0]
			&& $past(diagRunning[0]) && !$past(rst) |=> regRdData[7:6] == 2'h3)
			else $error("diag state missing");
	a_oc_flag_seen:
		assert property (overcurrentEvent[3] ##1 regRead && regAddr == 8'h10
			|=> regRdData[7]) else $error("overcurrent lost");
	a_dc_flag_seen:
		assert property (dcOffsetEvent[0] ##1 regRead && regAddr == 8'h10
			|=> regRdData[0]) else $error("dc fault lost");
	// Main scenarios reached
	c_thr_write: cover property (thrWr);
	c_state_reset: cover property (regRdValid && regRdData == 8'h55);
	c_pin_raised: cover property (diagFaultToPin);
endmodule
bind amp_diag_fault_status_regs amp_diag_fault_status_regs_asserts u_chk (
	.clk, .rst, .regAddr, .regWrite, .regWrData, .regRead, .regRdData,
	.regRdValid, .diagRunning, .overcurrentEvent, .dcOffsetEvent,
	.diagReportEnable, .diagFaultToPin, .shortThresholdCodeCh3,
	.shortThresholdCodeCh4
);

// >>> host_ctrl_model.sv
// Host controller model issuing register strobes.
// Each task is entered just after a falling edge of clk.
`timescale 1ns/1ns
module host_ctrl_model (
	// Clock
	input  wire logic       clk,
	// Register port toward the device
	output logic [7:0]      regAddr,
	output logic            regWrite,
	output logic [7:0]      regWrData,
	output logic            regRead,
	input  wire logic [7:0] regRdData,
	input  wire logic       regRdValid
);
	// Idle: no strobe, address parked off the map
	initial begin
		regAddr = 8'hFF;
		regWrite = 1'b0;
		regWrData = 8'h00;
		regRead = 1'b0;
	end
	// One write strobe; released lines show inverted values, not stale ones.
	// An idle cycle follows so a next call never retouches a line at once.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr = a;
		regWrData = d;
		regWrite = 1'b1;
		@(negedge clk);
		regWrite = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
		@(negedge clk);
	endtask
	// One read strobe; answer sampled while its valid pulse stands
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		regAddr = a;
		regRead = 1'b1;
		@(negedge clk);
		// Valid stands only in the cycle after the read edge
		d = regRdData;
		v = regRdValid;
		regRead = 1'b0;
		regAddr = ~a;
		@(negedge clk);
	endtask
endmodule

// >>> amp_diag_fault_status_regs_tb.sv
// Self-checking bench for the diagnostic status register group.
// Inputs change at falling edges; the host model makes register strobes.
`timescale 1ns/1ns
module amp_diag_fault_status_regs_tb;
	// Event row: oc, dc, global, line flags, read offset, expected byte
	typedef struct packed {
		logic [3:0] oc;
		logic [3:0] dc;
		logic [4:0] gf;
		logic [3:0] lo;
		logic [7:0] a;
		logic [7:0] e;
	} row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] regAddr, regWrData, regRdData, shortThresholdCh12;
	logic regWrite, regRead, regRdValid, lineOutputDone;
	logic diagReportEnable, diagFaultToPin;
	logic [3:0] diagRunning, lineOutputDetect, overcurrentEvent;
	logic [3:0] dcOffsetEvent, shortThresholdCodeCh3, shortThresholdCodeCh4;
	amp_diag_pkg::diag_meas_t diagMeas [4];
	amp_diag_pkg::chan_state_t appliedState [4];
	amp_diag_pkg::global_fault_t globalFaultEvent;
	int fails = 0;
	int check_count = 0;
	row_t rows [10] = '{{4'h8, 4'h0, 5'h00, 4'h0, 8'h10, 8'h80},
		{4'h0, 4'h1, 5'h00, 4'h0, 8'h10, 8'h01},
		{4'h5, 4'hA, 5'h00, 4'h0, 8'h10, 8'h5A},
		{4'h0, 4'h0, 5'h10, 4'h0, 8'h11, 8'h10},
		{4'h0, 4'h0, 5'h08, 4'h0, 8'h11, 8'h08},
		{4'h0, 4'h0, 5'h04, 4'h0, 8'h11, 8'h04},
		{4'h0, 4'h0, 5'h02, 4'h0, 8'h11, 8'h02},
		{4'h0, 4'h0, 5'h01, 4'h0, 8'h11, 8'h01},
		{4'h0, 4'h0, 5'h00, 4'hA, 8'h0E, 8'h0A},
		{4'h0, 4'h0, 5'h00, 4'h0, 8'h12, 8'h00}};
	// 250 MHz clock
	always #2 clk = ~clk;
	amp_diag_fault_status_regs u_amp_diag_fault_status_regs (.clk, .rst,
		.regAddr, .regWrite, .regWrData, .regRead, .regRdData, .regRdValid,
		.shortThresholdCh12, .diagMeas, .diagRunning, .lineOutputDetect,
		.lineOutputDone, .appliedState, .overcurrentEvent, .dcOffsetEvent,
		.globalFaultEvent, .diagReportEnable, .diagFaultToPin,
		.shortThresholdCodeCh3, .shortThresholdCodeCh4);
	host_ctrl_model u_host_ctrl_model (.clk, .regAddr, .regWrite, .regWrData,
		.regRead, .regRdData, .regRdValid);
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask
	// Read, then compare valid pulse and byte
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		u_host_ctrl_model.rd(a, d, v);
		chk8({7'h0, v}, 8'h01);
		chk8(d, e);
	endtask
	// Four measurements, ch1 in the top twelve bits
	task automatic diag(input logic [47:0] m);
		for (int i = 0; i < 4; i++)
			diagMeas[i] = m[47-12*i -: 12];
		@(negedge clk);
		for (int i = 0; i < 4; i++)
			diagMeas[i].done = 1'b0;
	endtask
	task automatic chkRst();
		logic [7:0] rv [7] = '{8'h11, 8'h00, 8'h00, 8'h00, 8'h55, 8'h00, 8'h00};
		chk8({shortThresholdCodeCh3, shortThresholdCodeCh4}, 8'h11);
		for (int i = 0; i < 7; i++)
			rdc(8'h0B + 8'(i), rv[i]);
		$display("reset values done");
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Run takes about 126 cycles; a hang is cut at 2000
	initial begin
		#8000;
		fails++;
		results();
	end
	initial begin
		shortThresholdCh12 = 8'h00;
		for (int i = 0; i < 4; i++) begin
			diagMeas[i] = '0;
			appliedState[i] = amp_diag_pkg::STATE_HIZ;
		end
		{diagRunning, lineOutputDetect, lineOutputDone} = '0;
		{overcurrentEvent, dcOffsetEvent, globalFaultEvent} = '0;
		diagReportEnable = 1'b0;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		chkRst();
		// Event pulse, read in the very next cycle
		foreach (rows[i]) begin
			{overcurrentEvent, dcOffsetEvent} = {rows[i].oc, rows[i].dc};
			{globalFaultEvent, lineOutputDetect} = {rows[i].gf, rows[i].lo};
			lineOutputDone = 1'b1;
			@(negedge clk);
			{overcurrentEvent, dcOffsetEvent, globalFaultEvent} = '0;
			lineOutputDone = 1'b0;
			rdc(rows[i].a, rows[i].e);
		end
		$display("event rows done");
		u_host_ctrl_model.wr(8'h10, 8'hFF);
		u_host_ctrl_model.wr(8'h0F, 8'h00);
		rdc(8'h10, 8'h00);
		rdc(8'h0F, 8'h55);
		u_host_ctrl_model.wr(8'h0B, 8'h9A);
		rdc(8'h0B, 8'h9A);
		chk8({shortThresholdCodeCh3, shortThresholdCodeCh4}, 8'h9A);
		// Threshold boundaries; ch4 code is reserved
		diag({12'hC00, 12'hA01, 12'h909, 12'h800});
		rdc(8'h0C, 8'h94);
		rdc(8'h0D, 8'h30);
		chk8({7'h0, diagFaultToPin}, 8'h00);
		diagReportEnable = 1'b1;
		@(negedge clk);
		chk8({7'h0, diagFaultToPin}, 8'h01);
		u_host_ctrl_model.wr(8'h0B, 8'h91);
		// Ch1 code 1 (one ohm), ch2 code reserved
		shortThresholdCh12 = 8'h1A;
		diag({12'h801, 12'h800, 12'h90A, 12'h801});
		rdc(8'h0C, 8'h10);
		rdc(8'h0D, 8'h21);
		diag({4{12'h8FF}});
		rdc(8'h0D, 8'h00);
		chk8({7'h0, diagFaultToPin}, 8'h00);
		$display("diagnostic results done");
		// Every reported state, then diagnostics overriding ch1
		for (int s = 0; s < 4; s++) begin
			for (int i = 0; i < 4; i++)
				appliedState[i] = amp_diag_pkg::chan_state_t'(s);
			@(negedge clk);
			rdc(8'h0F, {4{2'(s)}});
		end
		appliedState = '{amp_diag_pkg::STATE_PLAY, amp_diag_pkg::STATE_MUTE,
			amp_diag_pkg::STATE_HIZ, amp_diag_pkg::STATE_PLAY};
		diagRunning = 4'h1;
		@(negedge clk);
		rdc(8'h0F, 8'hE4);
		diagRunning = 4'h0;
		appliedState = '{4{amp_diag_pkg::STATE_HIZ}};
		$display("state readback done");
		// Second reset with flags pending
		overcurrentEvent = 4'hF;
		@(negedge clk);
		overcurrentEvent = 4'h0;
		rst = 1'b1;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		chkRst();
		results();
	end
endmodule
